//--- logic/drtp_core.sv
// Purpose: Cycle-level model of a 2048-bit three-phase dynamic RAM.
// Assumes: Phases and inputs are synchronous to clk; controller keeps its spacing.
// Notes: Refresh is a full three-phase cycle flagged by refresh; it inverts a column.
//
// Functional notes
// - Cycle starts when phase one falls; precharge.
// - Address inverted and latched during phase one.
// - One row and one column decoder after phase one.
// - Phase two senses addressed column onto lines.
// - Row multiplexer routes sensed bit to output stage.
// - Phase three drives conditioned input onto line.
// - Phase three stores line value into cell.
// - Refresh uses three phases, writes inverted state.
// - Each refresh complements the column's cells.
// - Read cycle may omit phase three.
// - Per-column inversion tracking bits kept.
// - Output is sensed bit xor tracking bit.
// - Output held until the next non-refresh phase-two sense.
// - Write stores input xor tracking bit.
`timescale 1ns/10ps
module drtp_core import drtp_pkg::*; #(
   parameter int ROWS_P = ROWS,
   parameter int COLS_P = COLS
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Phase inputs from the controller.
   input wire drtp_clk_s phases,
   // Address, data and refresh request.
   input wire logic [ADDR_W-1:0] addr,
   input wire logic data_in,
   input wire logic refresh,
   // Data output and state.
   output logic data_out,
   output logic cycle_busy
);
   typedef struct packed {
      drtp_phase_e st;
      logic [ADDR_W-1:0] addr_n;
      logic sense;
      logic refr;
      logic ph2_seen;
      logic ph3_seen;
      logic dout;
      logic busy;
      logic [COLS-1:0] track;
   } drtp_state_s;

   drtp_state_s s_q;
   drtp_state_s s_d;
   logic [COLS_P-1:0][ROWS_P-1:0] mem_q;
   drtp_dec_s dec;
   logic [ROW_W-1:0] row_idx;
   logic [COL_W-1:0] col_idx;
   logic dec_en;
   logic ph1;
   logic ph2;
   logic ph3;
   logic cell_bit;
   logic wr_bit;
   logic do_write;

   assign ph1 = ~phases.ph1_n;
   assign ph2 = ~phases.ph2_n;
   assign ph3 = ~phases.ph3_n;
   // Internal address lines hold the inverted address; undo it for decode.
   assign row_idx = ~s_q.addr_n[ROW_LSB +: ROW_W];
   assign col_idx = ~s_q.addr_n[COL_LSB +: COL_W];
   assign dec_en = (s_q.st == DRTP_DEC) || (s_q.st == DRTP_ACT);

   drtp_decode #(.IDX_W(ROW_W)) u_row (.idx(row_idx), .en(dec_en), .sel(dec.row_sel));
   drtp_decode #(.IDX_W(COL_W)) u_col (.idx(col_idx), .en(dec_en), .sel(dec.col_sel));

   // Row multiplexer picks the addressed bit of the selected column.
   assign cell_bit = mem_q[col_idx][row_idx];
   // Refresh writes back the inverted sensed state; a write conditions data in.
   assign wr_bit = s_q.refr ? ~s_q.sense : (data_in ^ s_q.track[col_idx]);
   assign do_write = ce && (s_q.st == DRTP_ACT) && ph3 && !s_q.ph3_seen;

   // Next-state logic for the cycle sequencer.
   always_comb begin
      s_d = s_q;
      unique case (s_q.st)
         DRTP_IDLE, DRTP_ACT: begin
            if (ph1) begin
               s_d.st = DRTP_PRE;
               // Take the address on the first sample too, so a one-cycle phase one works.
               s_d.addr_n = ~addr;
               s_d.refr = refresh;
               s_d.ph2_seen = 1'b0;
               s_d.ph3_seen = 1'b0;
            end
         end
         DRTP_PRE: begin
            // Only samples taken while phase one is low count, because the controller
            // may drop the refresh marker together with phase one.
            if (ph1) begin
               s_d.addr_n = ~addr;
               s_d.refr = refresh;
            end else begin
               s_d.st = DRTP_DEC;
            end
         end
         DRTP_DEC: begin
            if (ph2) begin
               s_d.st = DRTP_ACT;
            end
         end
      endcase
      // Sense happens on the first phase-two sample of the cycle.
      if (s_q.st == DRTP_ACT && ph2 && !s_q.ph2_seen) begin
         s_d.ph2_seen = 1'b1;
         s_d.sense = cell_bit;
         if (!s_q.refr) begin
            s_d.dout = cell_bit ^ s_q.track[col_idx];
         end
      end
      if (s_q.st == DRTP_DEC && ph2) begin
         s_d.ph2_seen = 1'b1;
         s_d.sense = cell_bit;
         if (!s_q.refr) begin
            s_d.dout = cell_bit ^ s_q.track[col_idx];
         end
      end
      if (do_write) begin
         s_d.ph3_seen = 1'b1;
         if (s_q.refr) begin
            s_d.track[col_idx] = ~s_q.track[col_idx];
         end
      end
      // Busy while any phase is low in a started cycle.
      s_d.busy = (s_d.st != DRTP_IDLE) && (ph1 || ph2 || ph3);
   end

   // State register; read cycles simply never see phase three.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '{st: DRTP_IDLE, addr_n: '1, sense: RST_BIT, refr: RST_BIT,
                  ph2_seen: RST_BIT, ph3_seen: RST_BIT, dout: RST_BIT, busy: RST_BIT,
                  track: '0};
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // Array storage; refresh inverts every cell of the addressed column.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_q <= '0;
      end else if (do_write) begin
         if (s_q.refr) begin
            mem_q[col_idx] <= ~mem_q[col_idx];
         end else begin
            mem_q[col_idx][row_idx] <= wr_bit;
         end
      end
   end

   // Outputs straight from flip-flops of the state register.
   assign data_out = s_q.dout;
   assign cycle_busy = s_q.busy;

   // Refresh of a column flips its tracking bit in the same write.
   property refresh_track_p;
      @(posedge clk) disable iff (!rstn)
      (do_write && s_q.refr) |=> (s_q.track[$past(col_idx)] != $past(s_q.track[col_idx]));
   endproperty
   track_toggle_a: assert property (refresh_track_p) else $error("track not toggled");

   // Output only changes on a phase-two sense.
   output_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !(ce && (s_q.st == DRTP_ACT || s_q.st == DRTP_DEC) && ph2 && !s_q.ph2_seen)
      |=> $stable(data_out)) else $error("output changed outside sense");

   // Phase one low moves the sequencer into precharge.
   cycle_start_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && ph1 && (s_q.st == DRTP_IDLE || s_q.st == DRTP_ACT)) |=> s_q.st == DRTP_PRE)
      else $error("cycle did not start");

   // Latched address lines are the complement of the applied address.
   addr_invert_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && ph1 && s_q.st != DRTP_DEC) |=> s_q.addr_n == ~$past(addr))
      else $error("address not inverted");

   // Exactly one row and one column line while decoded.
   one_hot_a: assert property (@(posedge clk) disable iff (!rstn)
      dec_en |-> ($onehot(dec.row_sel) && $onehot(dec.col_sel)))
      else $error("decode not one-hot");

   // Read output equals cell xor tracking bit.
   read_xor_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && s_q.st == DRTP_DEC && ph2 && !s_q.refr)
      |=> data_out == ($past(cell_bit) ^ $past(s_q.track[col_idx])))
      else $error("read data wrong");

   // A plain write stores input xor tracking bit.
   write_xor_a: assert property (@(posedge clk) disable iff (!rstn)
      (do_write && !s_q.refr) |=> mem_q[$past(col_idx)][$past(row_idx)]
      == ($past(data_in) ^ $past(s_q.track[col_idx])))
      else $error("write data wrong");

   // Refresh complements the cell that was sensed.
   refresh_inv_a: assert property (@(posedge clk) disable iff (!rstn)
      (do_write && s_q.refr) |=> mem_q[$past(col_idx)][$past(row_idx)] == ~$past(cell_bit))
      else $error("refresh did not invert");

   // Precharge ends when phase one rises; decoders are live on the next sample.
   sequence pre_end_s;
      ce && s_q.st == DRTP_PRE && !ph1;
   endsequence
   sequence dec_live_s;
      s_q.st == DRTP_DEC && dec_en;
   endsequence
   decode_step_a: assert property (@(posedge clk) disable iff (!rstn)
      pre_end_s |=> dec_live_s) else $error("decode not entered");

   // A refresh sense must not disturb the held read data.
   sequence refresh_sense_s;
      ce && s_q.st == DRTP_DEC && ph2 && s_q.refr;
   endsequence
   refresh_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      refresh_sense_s |=> $stable(data_out)) else $error("refresh changed output");

   // A long phase three still writes the cell only once per cycle.
   write_once_a: assert property (@(posedge clk) disable iff (!rstn)
      do_write |=> !do_write) else $error("second write in one cycle");
endmodule : drtp_core

//--- logic/drtp_decode.sv
// Purpose: One-hot decoder used for the row and column select lines.
// Assumes: Index is settled before enable rises.
// Notes: Exactly one output is high while enabled.
`timescale 1ns/10ps
module drtp_decode import drtp_pkg::*; #(
   parameter int IDX_W = 5
) (
   // Select input.
   input wire logic [IDX_W-1:0] idx,
   input wire logic en,
   // One-hot output.
   output logic [(1<<IDX_W)-1:0] sel
);
   // Decode the index into a single active line.
   always_comb begin
      sel = '0;
      if (en) begin
         sel[idx] = 1'b1;
      end
   end
endmodule : drtp_decode

//--- logic/drtp_pkg.sv
// Purpose: Shared constants and carriers for the three-phase dynamic RAM core.
// Assumes: Phases arrive as active-low levels sampled on clk.
// Notes: Array is 64 rows by 32 columns; low five address bits pick the column.
package drtp_pkg;
   localparam int ROW_W = 6;
   localparam int COL_W = 5;
   localparam int ADDR_W = ROW_W + COL_W;
   localparam int ROWS = 64;
   localparam int COLS = 32;
   localparam int COL_LSB = 0;
   localparam int ROW_LSB = COL_W;
   localparam logic RST_BIT = 1'h0;
   localparam int CLK_PERIOD_NS = 10;
   localparam int GAP_NS = 20;
   localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      DRTP_IDLE,
      DRTP_PRE,
      DRTP_DEC,
      DRTP_ACT
   } drtp_phase_e;

   // Three phase levels, active low, as driven by the controller.
   typedef struct packed {
      logic ph1_n;
      logic ph2_n;
      logic ph3_n;
   } drtp_clk_s;

   // Internal decoded address lines, one-hot.
   typedef struct packed {
      logic [ROWS-1:0] row_sel;
      logic [COLS-1:0] col_sel;
   } drtp_dec_s;
endpackage : drtp_pkg

//--- tb/drtp_ctrl.sv
// Purpose: Controller model issuing the three phases of one memory cycle.
// Assumes: go is a one-cycle request; op 0 read, 1 write, 2 refresh.
// Notes: done pulses once the closing gap has run out.
`timescale 1ns/10ps
module drtp_ctrl import drtp_pkg::*; (
   // Clock and request.
   input wire logic clk,
   input wire logic go,
   input wire logic [1:0] op,
   // Phases towards the memory.
   output drtp_clk_s phases,
   output logic refresh,
   output logic done
);
   // One process owns every output: idle levels first, then one cycle per request.
   initial begin
      phases = 3'h7;
      refresh = 1'h0;
      done = 1'h0;
      // Each phase stays low two cycles, so a one-cycle sampling slip still sees it.
      forever begin
         @(posedge clk iff go);
         #1 phases.ph1_n = 1'h0;
         refresh = (op == 2'h2);
         repeat (2) @(posedge clk);
         #1 phases.ph1_n = 1'h1;
         refresh = 1'h0;
         @(posedge clk);
         #1 phases.ph2_n = 1'h0;
         repeat (2) @(posedge clk);
         #1 phases.ph2_n = 1'h1;
         if (op != 2'h0) begin
            @(posedge clk);
            #1 phases.ph3_n = 1'h0;
            repeat (2) @(posedge clk);
            #1 phases.ph3_n = 1'h1;
         end
         repeat (GAP_CYC) @(posedge clk);
         #1 done = 1'h1;
         @(posedge clk);
         #1 done = 1'h0;
      end
   end
endmodule : drtp_ctrl

//--- tb/dynamic_ram_three_phase_cycle_test.sv
// Purpose: Self-checking bench for the three-phase dynamic RAM core.
// Assumes: The controller model keeps phase order and the closing gap.
// Notes: Reads must return the last written bit whatever refreshes came between.
`timescale 1ns/10ps
module dynamic_ram_three_phase_cycle_test;
   import drtp_pkg::*;
   logic clk, rstn, ce, go, data_in, data_out, cycle_busy, refresh, done;
   logic [1:0] op;
   logic [ADDR_W-1:0] addr;
   drtp_clk_s phases;
   logic ref_mem [ROWS*COLS];
   logic last_q;
   int bad_count, n_tests;
   drtp_core i_dut (.clk(clk), .rstn(rstn), .ce(ce), .phases(phases), .addr(addr),
      .data_in(data_in), .refresh(refresh), .data_out(data_out), .cycle_busy(cycle_busy));
   drtp_ctrl i_ctrl (.clk(clk), .go(go), .op(op), .phases(phases), .refresh(refresh),
      .done(done));
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic seen, input logic want);
      n_tests++;
      if (seen !== want) begin
         bad_count++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // Refresh is invisible to the user, so the expected bit is the last one written.
   function automatic logic want_rd(input logic [ADDR_W-1:0] a);
      return ref_mem[a];
   endfunction : want_rd
   // One cycle through the controller, then compare output and idle state.
   task automatic step(input logic [1:0] kind, input logic [ADDR_W-1:0] a, input logic d);
      int k;
      logic busy_seen;
      op = kind;
      addr = a;
      data_in = d;
      busy_seen = 1'h0;
      go = 1'h1;
      @(posedge clk);
      #1 go = 1'h0;
      // Done changes off the edge so it is read at the edge; busy is read just after it.
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (done) break;
         #1;
         busy_seen = busy_seen | cycle_busy;
      end
      if (k == 40) begin
         bad_count++;
         test_done();
      end
      #1;
      // Every non-refresh cycle senses, so data out shows the bit held before any write.
      if (kind != 2'h2 && ce) last_q = want_rd(a);
      if (kind == 2'h1 && ce) ref_mem[a] = d;
      check(data_out, last_q);
      check(cycle_busy, 1'h0);
      check(busy_seen, ce);
   endtask : step
   // Main sequence: corners first, then random traffic with a full refresh sweep.
   initial begin
      rstn = 1'h0;
      ce = 1'h1;
      go = 1'h0;
      op = 2'h0;
      addr = '0;
      data_in = 1'h0;
      bad_count = 0;
      n_tests = 0;
      last_q = 1'h0;
      foreach (ref_mem[i]) ref_mem[i] = 1'h0;
      void'($urandom(32'h303F));
      repeat (6) @(posedge clk);
      #1 rstn = 1'h1;
      step(2'h0, 11'h7FF, 1'h0);
      step(2'h1, 11'h7FF, 1'h1);
      step(2'h1, 11'h7DF, 1'h1);
      step(2'h2, 11'h01F, 1'h0);
      step(2'h0, 11'h7FF, 1'h0);
      step(2'h1, 11'h7FF, 1'h0);
      step(2'h2, 11'h03F, 1'h0);
      step(2'h0, 11'h7FF, 1'h0);
      step(2'h0, 11'h7DF, 1'h0);
      // With the clock enable low the whole write is ignored.
      ce = 1'h0;
      step(2'h1, 11'h7DF, 1'h0);
      ce = 1'h1;
      step(2'h0, 11'h7DF, 1'h0);
      for (int i = 0; i < 400; i++) begin
         if (i == 200) begin
            for (int c = 0; c < COLS; c++) step(2'h2, ADDR_W'($urandom), 1'h0);
            for (int c = 0; c < COLS; c++) step(2'h2, ADDR_W'(c), 1'h0);
         end
         step(2'($urandom % 3), ADDR_W'($urandom), 1'($urandom));
      end
      test_done();
   end
   // Watchdog sized well beyond 475 cycles of at most 12 clocks each.
   initial begin
      #300000;
      bad_count++;
      test_done();
   end
endmodule : dynamic_ram_three_phase_cycle_test
